/* jldoc_map.svh */
// register offsets, field positions, reset values and counts of the config slice
`ifndef JLDOC_MAP_SVH
`define JLDOC_MAP_SVH

// ****************************************************************
// register indices (byte address = index * 4)
// ****************************************************************
`define JLDOC_IDX_LANE     12'h20b
`define JLDOC_IDX_SYNC     12'h20f
`define JLDOC_IDX_GAIN     12'h210
`define JLDOC_IDX_THR_I    12'h211
`define JLDOC_IDX_THR_Q    12'h212
`define JLDOC_IDX_OVERRANGE_OUTPUT_CONFIG  12'h213
`define JLDOC_IDX_IRQ_STAT 12'h220
`define JLDOC_IDX_IRQ_MASK 12'h221
`define JLDOC_IDX_CLK_STAT 12'h222
`define JLDOC_IDX_SER_STAT 12'h223

// ****************************************************************
// reset values
// ****************************************************************
`define JLDOC_RST_LANE     8'h00
`define JLDOC_RST_SYNC     8'h00
`define JLDOC_RST_GAIN     8'h00
`define JLDOC_RST_THR_I    8'hf2
`define JLDOC_RST_THR_Q    8'hab
`define JLDOC_RST_OVERRANGE_OUTPUT_CONFIG  8'h07

// ****************************************************************
// fields and codes
// ****************************************************************
`define JLDOC_SER_BIT      0
`define JLDOC_GAIN_BIT     0
`define JLDOC_OVERRANGE_PIN_ENABLE_BIT   3
`define JLDOC_SHM_CRC      2'h0
`define JLDOC_SHM_FEC      2'h2
`define JLDOC_TP_OFF       4'h0
`define JLDOC_TP_ALT       4'h5
`define JLDOC_TP_RAMP      4'h4
`define JLDOC_CFG_EV_BIT   4
`define JLDOC_RSP_OK       2'h0
`define JLDOC_RSP_DECERR   2'h3
`define JLDOC_HOLD_BASE    11'h008

`endif

/* jldoc_pkg.sv */
// shared types of the config slice
package jldoc_pkg;

   // ****************************************************************
   // bus slave states and module state records
   // ****************************************************************
   typedef enum logic [1:0] {
      JLDOC_BUS_IDLE = 2'b01,
      JLDOC_BUS_ACK  = 2'b10
   } jldoc_bus_st_t;

   typedef struct packed {
      logic [15:0] smp;
      logic        flag;
      logic        vld;
   } jldoc_tag_st_t;

   typedef struct packed {
      logic [10:0] cnt;
      logic        hold;
   } jldoc_hold_st_t;

   typedef struct packed {
      jldoc_bus_st_t bus;
      logic [7:0]    lane;
      logic [7:0]    sync;
      logic [7:0]    gain;
      logic [7:0]    thr_i;
      logic [7:0]    thr_q;
      logic [7:0]    overrange_output_config;
      logic [4:0]    stat;
      logic [4:0]    mask;
      logic [31:0]   rdata;
      logic [1:0]    resp;
      logic [7:0]    clk_en;
      logic [7:0]    ser_en;
      logic [7:0]    ramp;
      logic [3:0]    xtp;
      logic          crc;
      logic          fec;
      logic [3:0]    pins;
   } jldoc_top_st_t;

endpackage : jldoc_pkg

/* jldoc_pulse_hold.sv */
// stretches an over-range tag to a minimum pin pulse
`timescale 1ns/10ps
`include "jldoc_map.svh"
module jldoc_pulse_hold
   import jldoc_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic [2:0] hold_exp,
   jldoc_tag_if.snk        tag,
   output logic            hold
);

   jldoc_hold_st_t st_q;
   jldoc_hold_st_t st_d;

   // ****************************************************************
   // retriggerable down counter, reload on every tag
   // ****************************************************************
   always_comb
   begin
      st_d = st_q;
      if (tag.flag)
         st_d.cnt = 11'(`JLDOC_HOLD_BASE << hold_exp);
      else if (st_q.cnt != 11'h000)
         st_d.cnt = st_q.cnt - 11'h001;
      st_d.hold = (st_d.cnt != 11'h000);
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
         st_q <= '0;
      else
         st_q <= st_d;
   end

   assign hold = st_q.hold;

   // ****************************************************************
   // checks
   // ****************************************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   chk_hold_start: assert property (tag.flag |=> hold)
      else $error("tag did not raise the hold");
   chk_hold_min: assert property ($rose(hold) |-> hold [*8])
      else $error("hold pulse shorter than eight cycles");

endmodule : jldoc_pulse_hold

/* jldoc_rx_model.sv */
// far-end link receiver model: counts lanes it can align on
`timescale 1ns/10ps
module jldoc_rx_model
   import jldoc_pkg::*;
(
   input  wire logic       clk,
   input  wire logic [7:0] ser_en,
   output logic      [3:0] live_lanes
);
   // only the unbroken run of serializer enables from lane 0 is counted, so a gap ends the count
   always_ff @(posedge clk)
   begin
      live_lanes <= 4'h0;
      for (int i = 0; i < 8; i++)
         if (&(ser_en | ~((8'h02 << i) - 8'h01))) live_lanes <= 4'(i + 1);
   end
endmodule : jldoc_rx_model

/* jldoc_sample_tag.sv */
// gain stage and over-range threshold tag for one downconverter stream
`timescale 1ns/10ps
`include "jldoc_map.svh"
module jldoc_sample_tag
   import jldoc_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       in_vld,
   input  wire logic [15:0] in_smp,
   input  wire logic       gain_en,
   input  wire logic [7:0] thresh,
   jldoc_tag_if.src        tag
);

   jldoc_tag_st_t st_q;
   jldoc_tag_st_t st_d;

   // doubling with saturation so the downconverter_extra_gain never wraps
   function automatic logic [15:0] sat2x(input logic [15:0] s);
      if (s[15] != s[14])
         return s[15] ? 16'h8000 : 16'h7fff;
      return {s[14:0], 1'b0};
   endfunction : sat2x

   // top eight magnitude bits, full scale is 256 steps
   function automatic logic [7:0] mag8(input logic [15:0] s);
      logic [15:0] a;
      a = s[15] ? 16'(-s) : s;
      if (a[15])
         a = 16'h7fff;
      return a[14:7];
   endfunction : mag8

   // ****************************************************************
   // next state: one sample per valid, tag aligned with it
   // ****************************************************************
   always_comb
   begin
      logic [15:0] s;
      s = gain_en ? sat2x(in_smp) : in_smp;
      st_d = st_q;
      st_d.vld = in_vld;
      st_d.flag = 1'b0;
      if (in_vld)
      begin
         st_d.smp = s;
         st_d.flag = (mag8(s) >= thresh);
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
         st_q <= '0;
      else
         st_q <= st_d;
   end

   assign tag.vld  = st_q.vld;
   assign tag.smp  = st_q.smp;
   assign tag.flag = st_q.flag;

   // ****************************************************************
   // checks
   // ****************************************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   chk_unity_gain: assert property (in_vld && !gain_en |=> tag.smp == $past(in_smp))
      else $error("unity gain changed the sample");
   chk_double_gain: assert property (in_vld && gain_en && in_smp[15] == in_smp[14]
      |=> tag.smp == {$past(in_smp[14:0]), 1'b0})
      else $error("downconverter_extra_gain did not double the sample");
   chk_flag_full: assert property (in_vld && !gain_en && in_smp == 16'h7fff |=> tag.flag)
      else $error("full scale sample not tagged");
   chk_flag_aligned: assert property (tag.flag |-> tag.vld)
      else $error("tag without its sample");

endmodule : jldoc_sample_tag

/* jldoc_tag_if.sv */
// tagged downconverter sample stream between tagger and pin stretcher
`timescale 1ns/10ps
interface jldoc_tag_if;
   logic        vld;
   logic [15:0] smp;
   logic        flag;
   modport src (output vld, output smp, output flag);
   modport snk (input vld, input smp, input flag);
endinterface : jldoc_tag_if

/* jldoc_top.sv */
// extra lane, sync header, downconverter gain and over-range configuration slice
//
// Notes on behaviour
// - extra lane bits enable second-link lane clocks
// - serializer bit adds serializers to extra lanes
// - extra lanes follow link format and pattern
// - pattern 0 or 5 gives ramp on extras
// - power-down and link-off override extra lanes
// - serializer needs all lower lanes enabled
// - sync mode 0 CRC, 2 FEC
// - sync mode applies only to 64b/66b
// - command fields in sync word are zero
// - gain bit doubles downconverter output
// - I samples tagged against threshold zero
// - Q samples tagged against threshold one
// - threshold is eight magnitude MSBs over 256
// - pin enable low holds pins low
// - pin pulse lasts 8 times two-to-exponent
//
// The implementer's own choice: the Avalon-MM register port.
`timescale 1ns/10ps
`include "jldoc_map.svh"
module jldoc_top
   import jldoc_pkg::*;
(
   input  wire logic        CLK_SYS,
   input  wire logic        RESET_N,
   input  wire logic [13:0] AVS_ADDRESS,
   input  wire logic        AVS_READ,
   input  wire logic        AVS_WRITE,
   input  wire logic [31:0] AVS_WRITEDATA,
   input  wire logic [3:0]  AVS_BYTEENABLE,
   output logic      [31:0] AVS_READDATA,
   output logic      [1:0]  AVS_RESPONSE,
   output logic             AVS_WAITREQUEST,
   input  wire logic        SERIAL_LINK_ENABLE,
   input  wire logic [3:0]  LINK_TEST_PATTERN_SELECT,
   input  wire logic [1:0]  CHANNEL_POWER_DOWN,
   input  wire logic [7:0]  LINK_FORMAT_LANES_B,
   input  wire logic        LINK_FORMAT_64B66B,
   input  wire logic [63:0] DDC_IN_DATA,
   input  wire logic [1:0]  DDC_IN_VALID,
   output logic      [63:0] DDC_OUT_DATA,
   output logic      [3:0]  DDC_OUT_CTRL,
   output logic      [1:0]  DDC_OUT_VALID,
   output logic      [7:0]  LANE_CLK_EN_B,
   output logic      [7:0]  LANE_SER_EN_B,
   output logic      [7:0]  LANE_RAMP_B,
   output logic      [3:0]  EXTRA_TEST_PATTERN,
   output logic             SYNC_CRC_EN,
   output logic             SYNC_FEC_EN,
   output logic      [7:0]  SYNC_CMD,
   output logic             OVERRANGE_PIN_A_ZERO,
   output logic             OVERRANGE_PIN_A_ONE,
   output logic             OVERRANGE_PIN_B_ZERO,
   output logic             OVERRANGE_PIN_B_ONE,
   output logic             IRQ
);

   // ****************************************************************
   // declarations
   // ****************************************************************
   jldoc_top_st_t st_q;
   jldoc_top_st_t st_d;
   logic          req;
   logic [11:0]   idx;
   logic          aligned;
   logic          wr_take;
   logic [3:0]    hold;
   logic [3:0]    flags;
   logic [7:0]    extra;
   logic [7:0]    lanes_on;
   logic [7:0]    ser_req;
   logic          link_up;
   logic          cfg_ev;

   jldoc_tag_if tag_if [4] ();

   // ****************************************************************
   // helpers
   // ****************************************************************

   // bit n high when every lane below n is on
   function automatic logic [7:0] lower_all(input logic [7:0] v);
      logic [7:0] r;
      r[0] = 1'b1;
      for (int i = 1; i < 8; i++)
         r[i] = r[i-1] & v[i-1];
      return r;
   endfunction : lower_all

   function automatic logic idx_hit(input logic [11:0] i);
      case (i)
         `JLDOC_IDX_LANE, `JLDOC_IDX_SYNC, `JLDOC_IDX_GAIN,
         `JLDOC_IDX_THR_I, `JLDOC_IDX_THR_Q, `JLDOC_IDX_OVERRANGE_OUTPUT_CONFIG,
         `JLDOC_IDX_IRQ_STAT, `JLDOC_IDX_IRQ_MASK,
         `JLDOC_IDX_CLK_STAT, `JLDOC_IDX_SER_STAT: return 1'b1;
         default: return 1'b0;
      endcase
   endfunction : idx_hit

   function automatic logic [7:0] rd_val(input logic [11:0] i,
                                         input jldoc_top_st_t s);
      case (i)
         `JLDOC_IDX_LANE:     return s.lane;
         `JLDOC_IDX_SYNC:     return s.sync;
         `JLDOC_IDX_GAIN:     return s.gain;
         `JLDOC_IDX_THR_I:    return s.thr_i;
         `JLDOC_IDX_THR_Q:    return s.thr_q;
         `JLDOC_IDX_OVERRANGE_OUTPUT_CONFIG:  return s.overrange_output_config;
         `JLDOC_IDX_IRQ_STAT: return {3'h0, s.stat};
         `JLDOC_IDX_IRQ_MASK: return {3'h0, s.mask};
         `JLDOC_IDX_CLK_STAT: return s.clk_en;
         `JLDOC_IDX_SER_STAT: return s.ser_en;
         default:             return 8'h00;
      endcase
   endfunction : rd_val

   // ****************************************************************
   // sample streams: 0 A-I, 1 A-Q, 2 B-I, 3 B-Q
   // ****************************************************************
   for (genvar k = 0; k < 4; k++)
   begin : g_stream
      jldoc_sample_tag u_tag (
         .clk     (CLK_SYS),
         .rst_n   (RESET_N),
         .in_vld  (DDC_IN_VALID[k/2]),
         .in_smp  (DDC_IN_DATA[16*k +: 16]),
         .gain_en (st_q.gain[`JLDOC_GAIN_BIT]),
         .thresh  ((k % 2 == 1) ? st_q.thr_q : st_q.thr_i),
         .tag     (tag_if[k].src)
      );
      jldoc_pulse_hold u_hold (
         .clk      (CLK_SYS),
         .rst_n    (RESET_N),
         .hold_exp (st_q.overrange_output_config[2:0]),
         .tag      (tag_if[k].snk),
         .hold     (hold[k])
      );
      assign DDC_OUT_DATA[16*k +: 16] = tag_if[k].smp;
      assign flags[k] = tag_if[k].flag;
   end

   // in-band tags go out regardless of the pin enable
   assign DDC_OUT_CTRL  = flags;
   assign DDC_OUT_VALID = {tag_if[2].vld, tag_if[0].vld};

   // ****************************************************************
   // bus decode
   // ****************************************************************
   assign req     = AVS_READ | AVS_WRITE;
   assign idx     = AVS_ADDRESS[13:2];
   assign aligned = (AVS_ADDRESS[1:0] == 2'h0);
   // a write lands only at the edge where waitrequest is low
   assign wr_take = AVS_WRITE & (st_q.bus == JLDOC_BUS_ACK)
                    & AVS_BYTEENABLE[0] & aligned;

   // ****************************************************************
   // lane enables
   // ****************************************************************
   // channel B power-down covers the whole second link
   assign link_up  = SERIAL_LINK_ENABLE & ~CHANNEL_POWER_DOWN[1];
   assign extra    = {st_q.lane[7:1], 1'b0};
   assign lanes_on = LINK_FORMAT_LANES_B | extra;
   // extra lanes get serializers only with the serializer bit
   assign ser_req  = LINK_FORMAT_LANES_B
                     | (extra & {8{st_q.lane[`JLDOC_SER_BIT]}});

   // a lane or sync write under a live link is flagged, not blocked
   assign cfg_ev = wr_take & SERIAL_LINK_ENABLE
                   & (idx == `JLDOC_IDX_LANE || idx == `JLDOC_IDX_SYNC);

   // ****************************************************************
   // next state
   // ****************************************************************
   always_comb
   begin
      logic [4:0] clr;
      logic [4:0] ev;
      clr = '0;
      ev  = {cfg_ev, flags};
      st_d = st_q;

      // two-cycle slave: latch answer, then release
      case (st_q.bus)
         JLDOC_BUS_IDLE:
         begin
            if (req)
            begin
               st_d.bus = JLDOC_BUS_ACK;
               st_d.rdata = {24'h0, rd_val(idx, st_q)};
               st_d.resp = (aligned && idx_hit(idx)) ? `JLDOC_RSP_OK
                                                     : `JLDOC_RSP_DECERR;
               if (!(aligned && idx_hit(idx)))
                  st_d.rdata = '0;
            end
         end
         JLDOC_BUS_ACK:
            st_d.bus = JLDOC_BUS_IDLE;
         default:
            st_d.bus = JLDOC_BUS_IDLE;
      endcase

      // register writes, low byte lane only
      if (wr_take)
      begin
         case (idx)
            `JLDOC_IDX_LANE:     st_d.lane = AVS_WRITEDATA[7:0];
            `JLDOC_IDX_SYNC:     st_d.sync = AVS_WRITEDATA[7:0];
            `JLDOC_IDX_GAIN:     st_d.gain = AVS_WRITEDATA[7:0];
            `JLDOC_IDX_THR_I:    st_d.thr_i = AVS_WRITEDATA[7:0];
            `JLDOC_IDX_THR_Q:    st_d.thr_q = AVS_WRITEDATA[7:0];
            `JLDOC_IDX_OVERRANGE_OUTPUT_CONFIG:  st_d.overrange_output_config = AVS_WRITEDATA[7:0];
            `JLDOC_IDX_IRQ_STAT: clr = AVS_WRITEDATA[4:0];
            `JLDOC_IDX_IRQ_MASK: st_d.mask = AVS_WRITEDATA[4:0];
            default:             clr = '0;
         endcase
      end

      // sticky status: a new event beats a clear in the same cycle
      st_d.stat = (st_q.stat & ~clr) | ev;

      // lane clocks and serializers, all dropped when link is down
      st_d.clk_en = link_up ? lanes_on : 8'h00;
      st_d.ser_en = link_up ? (ser_req & lower_all(lanes_on)) : 8'h00;

      // lanes only the extra field enables use the link's pattern,
      // except a ramp replaces no-pattern and pattern 5
      if (LINK_TEST_PATTERN_SELECT == `JLDOC_TP_OFF
          || LINK_TEST_PATTERN_SELECT == `JLDOC_TP_ALT)
         st_d.xtp = `JLDOC_TP_RAMP;
      else
         st_d.xtp = LINK_TEST_PATTERN_SELECT;
      st_d.ramp = (st_d.xtp == `JLDOC_TP_RAMP)
                  ? (st_d.clk_en & extra & ~LINK_FORMAT_LANES_B) : 8'h00;

      // sync word content, only for 64b/66b formats; reserved codes send neither
      st_d.crc = LINK_FORMAT_64B66B && st_q.sync[1:0] == `JLDOC_SHM_CRC;
      st_d.fec = LINK_FORMAT_64B66B && st_q.sync[1:0] == `JLDOC_SHM_FEC;

      // pins gated by the enable, stretched pulses from the hold units
      st_d.pins = st_q.overrange_output_config[`JLDOC_OVERRANGE_PIN_ENABLE_BIT] ? hold : 4'h0;
   end

   // ****************************************************************
   // state register
   // ****************************************************************
   always_ff @(posedge CLK_SYS)
   begin
      if (!RESET_N)
      begin
         st_q         <= '0;
         st_q.bus     <= JLDOC_BUS_IDLE;
         st_q.lane    <= `JLDOC_RST_LANE;
         st_q.sync    <= `JLDOC_RST_SYNC;
         st_q.gain    <= `JLDOC_RST_GAIN;
         st_q.thr_i   <= `JLDOC_RST_THR_I;
         st_q.thr_q   <= `JLDOC_RST_THR_Q;
         st_q.overrange_output_config <= `JLDOC_RST_OVERRANGE_OUTPUT_CONFIG;
      end
      else
         st_q <= st_d;
   end

   // ****************************************************************
   // outputs
   // ****************************************************************
   assign AVS_WAITREQUEST    = req & (st_q.bus != JLDOC_BUS_ACK);
   assign AVS_READDATA       = st_q.rdata;
   assign AVS_RESPONSE       = st_q.resp;
   assign LANE_CLK_EN_B      = st_q.clk_en;
   assign LANE_SER_EN_B      = st_q.ser_en;
   assign LANE_RAMP_B        = st_q.ramp;
   assign EXTRA_TEST_PATTERN = st_q.xtp;
   assign SYNC_CRC_EN        = st_q.crc;
   assign SYNC_FEC_EN        = st_q.fec;
   // no command channel: idle headers always
   assign SYNC_CMD           = 8'h00;
   assign OVERRANGE_PIN_A_ZERO = st_q.pins[0];
   assign OVERRANGE_PIN_A_ONE  = st_q.pins[1];
   assign OVERRANGE_PIN_B_ZERO = st_q.pins[2];
   assign OVERRANGE_PIN_B_ONE  = st_q.pins[3];
   assign IRQ                = |(st_q.stat & st_q.mask);

   // ****************************************************************
   // checks
   // ****************************************************************
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (!RESET_N);

   chk_link_down_off: assert property (!link_up |=> LANE_CLK_EN_B == 8'h00
      && LANE_SER_EN_B == 8'h00)
      else $error("lanes active with link down");
   chk_extra_clk: assert property (link_up |=> LANE_CLK_EN_B
      == ($past(LINK_FORMAT_LANES_B) | {$past(st_q.lane[7:1]), 1'b0}))
      else $error("extra lane clock mismatch");
   chk_ser_off: assert property (!st_q.lane[`JLDOC_SER_BIT]
      |=> (LANE_SER_EN_B & ~$past(LINK_FORMAT_LANES_B)) == 8'h00)
      else $error("extra serializer on without serializer bit");
   chk_ser_prefix: assert property ((LANE_SER_EN_B
      & ~lower_all(LANE_CLK_EN_B)) == 8'h00)
      else $error("serializer on above a disabled lane");
   chk_ramp_pattern: assert property (LANE_RAMP_B != 8'h00
      |-> EXTRA_TEST_PATTERN == `JLDOC_TP_RAMP)
      else $error("ramp lanes without ramp pattern");
   chk_pattern_follow: assert property (LINK_TEST_PATTERN_SELECT == 4'h1
      |=> EXTRA_TEST_PATTERN == 4'h1 && LANE_RAMP_B == 8'h00)
      else $error("extra lanes left the link pattern");
   chk_sync_fec: assert property (LINK_FORMAT_64B66B
      && st_q.sync[1:0] == `JLDOC_SHM_FEC |=> SYNC_FEC_EN && !SYNC_CRC_EN)
      else $error("fec mode not selected");
   chk_sync_8b10b: assert property (!LINK_FORMAT_64B66B
      |=> !SYNC_FEC_EN && !SYNC_CRC_EN)
      else $error("sync mode active outside 64b/66b");
   chk_pin_gate: assert property (!st_q.overrange_output_config[`JLDOC_OVERRANGE_PIN_ENABLE_BIT]
      |=> !OVERRANGE_PIN_A_ZERO && !OVERRANGE_PIN_B_ONE)
      else $error("over-range pin high while disabled");
   chk_pin_follow: assert property (flags[0] && st_q.overrange_output_config[`JLDOC_OVERRANGE_PIN_ENABLE_BIT]
      ##1 st_q.overrange_output_config[`JLDOC_OVERRANGE_PIN_ENABLE_BIT] |=> OVERRANGE_PIN_A_ZERO)
      else $error("I tag did not reach its pin");

   cov_fec: cover property (SYNC_FEC_EN);
   cov_ramp: cover property (LANE_RAMP_B != 8'h00);
   cov_pin: cover property (OVERRANGE_PIN_B_ONE);
   cov_irq: cover property (IRQ);

endmodule : jldoc_top

/* tb.sv */
// self-checking bench for the lane, sync, gain and over-range slice
`timescale 1ns/10ps
`include "jldoc_map.svh"
module tb;
   import jldoc_pkg::*;
   logic        clk = 0, rst_n = 0, rd = 0, wr = 0, link = 0, f66 = 1;
   logic [13:0] adr = 0;
   logic [31:0] wdat = 0, rdat;
   logic [3:0]  tp = 0, ctrl, live, xtp;
   logic [1:0]  pd = 0, vin = 0, resp, vout;
   logic [63:0] din = 0, dout;
   logic [7:0]  clk_en, ser_en, ramp, cmd;
   logic        wreq, crc, fec, pa0, pa1, pb0, pb1, irq;
   int          n_errors = 0, n_compared = 0;
   // free-running 40 MHz clock
   always #12.5 clk = ~clk;
   jldoc_top uut (.CLK_SYS(clk), .RESET_N(rst_n), .AVS_ADDRESS(adr), .AVS_READ(rd),
      .AVS_WRITE(wr), .AVS_WRITEDATA(wdat), .AVS_BYTEENABLE(4'hf), .AVS_READDATA(rdat),
      .AVS_RESPONSE(resp), .AVS_WAITREQUEST(wreq), .SERIAL_LINK_ENABLE(link),
      .LINK_TEST_PATTERN_SELECT(tp), .CHANNEL_POWER_DOWN(pd), .LINK_FORMAT_LANES_B(8'h01),
      .LINK_FORMAT_64B66B(f66), .DDC_IN_DATA(din), .DDC_IN_VALID(vin), .DDC_OUT_DATA(dout),
      .DDC_OUT_CTRL(ctrl), .DDC_OUT_VALID(vout), .LANE_CLK_EN_B(clk_en),
      .LANE_SER_EN_B(ser_en), .LANE_RAMP_B(ramp), .EXTRA_TEST_PATTERN(xtp), .SYNC_CRC_EN(crc),
      .SYNC_FEC_EN(fec), .SYNC_CMD(cmd), .OVERRANGE_PIN_A_ZERO(pa0), .OVERRANGE_PIN_A_ONE(pa1),
      .OVERRANGE_PIN_B_ZERO(pb0), .OVERRANGE_PIN_B_ONE(pb1), .IRQ(irq));
   jldoc_rx_model rx (.clk(clk), .ser_en(ser_en), .live_lanes(live));
   // ****************************************************************
   // shared tasks
   // ****************************************************************
   task automatic complete_run;
      $display("compared %0d errors %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : complete_run
   task automatic chk(input logic [71:0] seen, input logic [71:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   // request held until waitrequest is seen low at a rising edge; that edge completes it
   task automatic bus(input logic w, input logic [11:0] i, input logic [7:0] d,
                      output logic [31:0] q, output logic [1:0] r);
      int n;
      n = 0;
      @(posedge clk);
      adr <= {i, 2'b00};
      wdat <= {24'h0, d};
      wr <= w;
      rd <= ~w;
      @(posedge clk);
      while (wreq !== 1'b0 && n < 50)
      begin
         @(posedge clk);
         n++;
      end
      if (n >= 50)
      begin
         n_errors++;
         complete_run();
      end
      q = rdat;
      r = resp;
      wr <= 1'b0;
      rd <= 1'b0;
   endtask : bus
   task automatic wrt(input logic [11:0] i, input logic [7:0] d);
      logic [31:0] q;
      logic [1:0]  r;
      bus(1'b1, i, d, q, r);
   endtask : wrt
   task automatic rdc(input logic [11:0] i, input logic [7:0] e, input logic [1:0] er);
      logic [31:0] q;
      logic [1:0]  r;
      bus(1'b0, i, 8'h00, q, r);
      chk(q, {24'h0, e});
      chk(r, er);
   endtask : rdc
   task automatic settle;
      repeat (3) @(posedge clk);
      #1;
   endtask : settle
   // one sample on all four streams, outputs looked at one cycle later
   task automatic smp(input logic [63:0] d);
      @(posedge clk);
      din <= d;
      vin <= 2'b11;
      @(posedge clk);
      vin <= 2'b00;
      #1;
   endtask : smp
   task automatic pins(input int e);
      int n;
      n = 0;
      repeat (40)
      begin
         @(posedge clk);
         #1;
         if (pa0 === 1'b1) n++;
         // A-one pin tracks A-zero here, B pins stay low
         if ({pb1, pb0, pa1} !== {2'b00, pa0}) n += 100;
      end
      chk(n, e);
   endtask : pins
   // main sequence
   initial
   begin
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      rdc(`JLDOC_IDX_LANE, 8'h00, 2'h0);
      rdc(`JLDOC_IDX_SYNC, 8'h00, 2'h0);
      rdc(`JLDOC_IDX_GAIN, 8'h00, 2'h0);
      rdc(`JLDOC_IDX_THR_I, 8'hf2, 2'h0);
      rdc(`JLDOC_IDX_THR_Q, 8'hab, 2'h0);
      rdc(`JLDOC_IDX_OVERRANGE_OUTPUT_CONFIG, 8'h07, 2'h0);
      rdc(12'h300, 8'h00, 2'h3);
      wrt(`JLDOC_IDX_LANE, 8'h0a);
      link <= 1'b1;
      settle();
      chk(ser_en, 8'h01);
      @(posedge clk) link <= 1'b0;
      wrt(`JLDOC_IDX_LANE, 8'h0b);
      link <= 1'b1;
      settle();
      chk(clk_en, 8'h0b);
      chk(ser_en, 8'h03);
      chk(live, 4'h2);
      rdc(`JLDOC_IDX_CLK_STAT, 8'h0b, 2'h0);
      rdc(`JLDOC_IDX_SER_STAT, 8'h03, 2'h0);
      wrt(`JLDOC_IDX_LANE, 8'h0b);
      chk(ramp, 8'h0a);
      chk(xtp, 4'h4);
      @(posedge clk) tp <= 4'h3;
      settle();
      chk({ramp, xtp}, 12'h003);
      @(posedge clk) pd <= 2'b10;
      settle();
      chk(clk_en, 8'h00);
      @(posedge clk) link <= 1'b0;
      for (int m = 0; m < 4; m++)
      begin
         wrt(`JLDOC_IDX_SYNC, 8'(m));
         settle();
         chk({crc, fec, cmd}, {m == 0, m == 2, 8'h00});
      end
      wrt(`JLDOC_IDX_SYNC, 8'h00);
      f66 <= 1'b0;
      settle();
      chk(crc, 1'b0);
      wrt(`JLDOC_IDX_THR_I, 8'h10);
      wrt(`JLDOC_IDX_THR_Q, 8'h10);
      wrt(`JLDOC_IDX_OVERRANGE_OUTPUT_CONFIG, 8'h08);
      wrt(`JLDOC_IDX_IRQ_MASK, 8'h01);
      smp(64'h07ff_f801_f800_0800);
      chk({ctrl, vout, dout}, {4'h3, 2'h3, 64'h07ff_f801_f800_0800});
      pins(8);
      chk(irq, 1'b1);
      rdc(`JLDOC_IDX_IRQ_STAT, 8'h13, 2'h0);
      wrt(`JLDOC_IDX_IRQ_MASK, 8'h00);
      #1;
      chk(irq, 1'b0);
      wrt(`JLDOC_IDX_IRQ_STAT, 8'h1f);
      rdc(`JLDOC_IDX_IRQ_STAT, 8'h00, 2'h0);
      wrt(`JLDOC_IDX_OVERRANGE_OUTPUT_CONFIG, 8'h00);
      wrt(`JLDOC_IDX_GAIN, 8'h01);
      smp(64'h0000_0000_0000_0400);
      chk({ctrl, vout, dout}, {4'h1, 2'h3, 64'h0000_0000_0000_0800});
      pins(0);
      wrt(`JLDOC_IDX_GAIN, 8'h00);
      smp(64'h7fff_0000_0000_0000);
      chk({ctrl, vout, dout}, {4'h8, 2'h3, 64'h7fff_0000_0000_0000});
      complete_run();
   end
endmodule : tb
